//--- hdl/ghc_pkg.sv
// Shared constants for the gauge housekeeping and scheduling block
package ghc_pkg;
  // Core clock and time units
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_H = 3600;
  // Scheduling intervals
  localparam int RUN_INTERVAL_MS = 250;
  localparam int LIFE_STATS_H = 10;
  localparam int LIFE_TIME_H = 2;
  localparam int LIFE_STATS_S = LIFE_STATS_H * S_PER_H;
  localparam int LIFE_TIME_S = LIFE_TIME_H * S_PER_H;
  // Bus-off detection: one extra tick covers the unknown phase of the first tick
  localparam int BUS_OFF_S = 2;
  localparam int BUS_OFF_TICKS = BUS_OFF_S * MS_PER_S + 1;
  localparam int BUS_RESUME_MS = 1;
  // Register bus
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SLEEP = 8'h08;
  localparam logic [7:0] OFS_BAL = 8'h0C;
  localparam logic [7:0] OFS_TRIP = 8'h10;
  localparam logic [7:0] OFS_TEMP = 8'h14;
  localparam logic [7:0] OFS_LED = 8'h18;
  localparam logic [7:0] OFS_COUNT = 8'h1C;
  localparam logic [7:0] OFS_WAKE = 8'h20;
  localparam logic [7:0] OFS_AUTH = 8'h24;
  localparam logic [7:0] OFS_THERM = 8'h28;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TRIP_EN = 2;
  localparam int CTRL_MASTER = 3;
  localparam int CTRL_PEC = 4;
  localparam int CTRL_BAL_EN = 5;
  localparam logic [1:0] MODE_REQ_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REQ_SLEEP = 2'h1;
  localparam logic [1:0] MODE_REQ_SHUTDOWN = 2'h2;
  // Reset values
  localparam logic [7:0] SLEEP_RST = 8'h14;
  localparam logic [15:0] BAL_RST = 16'h0FA0;
  localparam logic [15:0] TRIP_SET_RST = 16'h0000;
  localparam logic [15:0] TRIP_CLR_RST = 16'h0000;
  localparam logic [15:0] WAKE_RST = 16'h0010;
  localparam logic [2:0] LED_SEGS_RST = 3'h5;
  // LED display contents
  localparam logic [1:0] LED_SHOW_CAP = 2'h0;
  localparam logic [1:0] LED_SHOW_FAULT = 2'h1;
  localparam logic [1:0] LED_SHOW_BOTH = 2'h2;
  localparam int PERCENT_FULL = 100;
  localparam int NCELL = 4;
  localparam int NTEMP = 5;
  localparam int NSEG = 5;
  typedef enum logic [1:0] {GHC_NORMAL, GHC_SLEEP, GHC_SHUTDOWN} ghc_mode_e;
endpackage

//--- hdl/ghc_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module ghc_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- hdl/ghc_bus_off.sv
// Detects the bus-off state from synchronised bus line levels
`timescale 1ns/1ps
module ghc_bus_off #(
  parameter int LIMIT_TICKS = ghc_pkg::BUS_OFF_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ms_tick,
  input wire logic enable,
  input wire logic clk_line,
  input wire logic data_line,
  output logic bus_off
);
  logic [15:0] low_ms;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_ms <= '0;
      bus_off <= 1'b0;
    end else if (!enable || clk_line || data_line) begin
      // Any high line restarts the timer and leaves bus-off at once
      low_ms <= '0;
      bus_off <= 1'b0;
    end else if (ms_tick && !bus_off) begin
      if (low_ms == 16'(LIMIT_TICKS - 1)) begin
        bus_off <= 1'b1;
      end else begin
        low_ms <= low_ms + 16'h0001;
      end
    end
  end
endmodule

//--- hdl/ghc_top.sv
// Housekeeping, scheduling and bus-state control of the gas gauge
`timescale 1ns/1ps
module ghc_top #(
  parameter int MS_CYCLES = ghc_pkg::MS_CYCLES,
  parameter int MS_PER_S = ghc_pkg::MS_PER_S,
  parameter int LIFE_STATS_S = ghc_pkg::LIFE_STATS_S,
  parameter int LIFE_TIME_S = ghc_pkg::LIFE_TIME_S
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic BUS_CLOCK_PIN_IN,
  output logic BUS_CLOCK_PIN_OUT,
  output logic BUS_CLOCK_PIN_OE,
  input wire logic BUS_DATA_PIN_IN,
  output logic BUS_DATA_PIN_OUT,
  output logic BUS_DATA_PIN_OE,
  input wire logic BUS_CLOCK_PULL_LOW,
  input wire logic BUS_DATA_PULL_LOW,
  output logic BUS_CLOCK_SEEN,
  output logic BUS_DATA_SEEN,
  output logic BUS_ACTIVE,
  output logic BUS_MASTER_EN,
  output logic BUS_PEC_EN,
  input wire logic signed [15:0] SENSE_POS_INPUT,
  input wire logic signed [15:0] SENSE_NEG_INPUT,
  input wire logic SENSE_VALID,
  output logic CHARGING,
  output logic DISCHARGING,
  input wire logic [63:0] CELL_VOLT,
  output logic [3:0] BALANCE,
  output logic CELL_VOLT_REFRESH,
  input wire logic [15:0] REMAINING_CHARGE_VALUE,
  output logic TRIP_POINT_IRQ,
  output logic TRIP_POINT_IRQ_PULLUP_EN,
  input wire logic LIFE_STATS_DIFF,
  input wire logic LIFE_TIME_DIFF,
  output logic LIFE_STATS_COPY,
  output logic LIFE_TIME_COPY,
  output logic MEAS_RUN,
  input wire logic RUN_DONE,
  output logic REDUCED_POWER,
  output logic SHUTDOWN_ACTIVE,
  input wire logic FAULT_DETECT,
  input wire logic PERMANENT_FAULT,
  input wire logic [4:0] PERMANENT_FAULT_CODE,
  input wire logic [6:0] RELATIVE_CHARGE_PERCENT,
  output logic [4:0] LED_SEG,
  output logic [4:0] TEMP_EN,
  output logic [4:0] TEMP_IS_FET,
  output logic [7:0] CELL_THERM_MODEL,
  output logic [7:0] FET_THERM_MODEL,
  output logic AUTH_START,
  input wire logic AUTH_DONE
);
  ghc_pkg::ghc_mode_e mode;
  logic trip_en;
  logic bal_en;
  logic [7:0] sleep_intv;
  logic [15:0] bal_thresh;
  logic [15:0] trip_set;
  logic [15:0] trip_clr;
  logic [15:0] wake_thresh;
  logic [2:0] led_segs;
  logic [1:0] led_show;
  logic auth_done_flag;
  logic run_active;
  logic [31:0] ms_cnt;
  logic ms_tick;
  logic [15:0] run_ms;
  logic run_tick;
  logic [7:0] sleep_cnt;
  logic [15:0] sec_ms;
  logic sec_tick;
  logic [31:0] stats_s;
  logic [31:0] time_s;
  logic signed [31:0] charge_count;
  logic signed [16:0] sense_diff;
  logic [16:0] sense_mag;
  logic [1:0] lines_sync;
  logic bus_off;
  logic alive;
  logic show_phase;
  logic [15:0] min_cell;
  logic next_wake;

  assign alive = (mode != ghc_pkg::GHC_SHUTDOWN);

  // Pin synchroniser and bus-off watch
  ghc_sync #(.W(2)) i_ghc_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d({BUS_CLOCK_PIN_IN, BUS_DATA_PIN_IN}),
    .q(lines_sync)
  );

  ghc_bus_off #(.LIMIT_TICKS(ghc_pkg::BUS_OFF_TICKS)) i_ghc_bus_off (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ms_tick(ms_tick),
    .enable(alive),
    .clk_line(lines_sync[1]),
    .data_line(lines_sync[0]),
    .bus_off(bus_off)
  );

  // Open-drain lines only pulled low, never while off or shut down
  assign BUS_CLOCK_PIN_OUT = 1'b0;
  assign BUS_DATA_PIN_OUT = 1'b0;
  assign BUS_CLOCK_PIN_OE = BUS_CLOCK_PULL_LOW && BUS_ACTIVE;
  assign BUS_DATA_PIN_OE = BUS_DATA_PULL_LOW && BUS_ACTIVE;
  assign BUS_CLOCK_SEEN = lines_sync[1];
  assign BUS_DATA_SEEN = lines_sync[0];
  assign BUS_ACTIVE = alive && !bus_off;
  assign SHUTDOWN_ACTIVE = !alive;
  assign REDUCED_POWER = !run_active;
  assign TRIP_POINT_IRQ_PULLUP_EN = trip_en && alive;

  // Register writes
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      trip_en <= 1'b0;
      bal_en <= 1'b0;
      BUS_MASTER_EN <= 1'b0;
      BUS_PEC_EN <= 1'b0;
      sleep_intv <= ghc_pkg::SLEEP_RST;
      bal_thresh <= ghc_pkg::BAL_RST;
      trip_set <= ghc_pkg::TRIP_SET_RST;
      trip_clr <= ghc_pkg::TRIP_CLR_RST;
      wake_thresh <= ghc_pkg::WAKE_RST;
      led_segs <= ghc_pkg::LED_SEGS_RST;
      led_show <= ghc_pkg::LED_SHOW_CAP;
      TEMP_EN <= '0;
      TEMP_IS_FET <= '0;
      CELL_THERM_MODEL <= '0;
      FET_THERM_MODEL <= '0;
    end else if (WR) begin
      case (ADDR)
        ghc_pkg::OFS_CTRL: begin
          trip_en <= WDATA[ghc_pkg::CTRL_TRIP_EN];
          BUS_MASTER_EN <= WDATA[ghc_pkg::CTRL_MASTER];
          BUS_PEC_EN <= WDATA[ghc_pkg::CTRL_PEC];
          bal_en <= WDATA[ghc_pkg::CTRL_BAL_EN];
        end
        ghc_pkg::OFS_SLEEP: sleep_intv <= WDATA[7:0];
        ghc_pkg::OFS_BAL: bal_thresh <= WDATA[15:0];
        ghc_pkg::OFS_TRIP: begin
          trip_set <= WDATA[15:0];
          trip_clr <= WDATA[31:16];
        end
        ghc_pkg::OFS_TEMP: begin
          TEMP_EN <= WDATA[4:0];
          TEMP_IS_FET <= WDATA[12:8];
        end
        ghc_pkg::OFS_LED: begin
          led_segs <= WDATA[2:0];
          led_show <= WDATA[5:4];
        end
        ghc_pkg::OFS_WAKE: wake_thresh <= WDATA[15:0];
        ghc_pkg::OFS_THERM: begin
          CELL_THERM_MODEL <= WDATA[7:0];
          FET_THERM_MODEL <= WDATA[15:8];
        end
        default: ;
      endcase
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !RD) begin
      RDATA <= '0;
    end else begin
      case (ADDR)
        ghc_pkg::OFS_CTRL: RDATA <= {26'h0, bal_en, BUS_PEC_EN, BUS_MASTER_EN, trip_en,
                                     mode};
        ghc_pkg::OFS_STATUS: RDATA <= {25'h0, auth_done_flag, bus_off, TRIP_POINT_IRQ,
                                       DISCHARGING, CHARGING, mode};
        ghc_pkg::OFS_SLEEP: RDATA <= {24'h0, sleep_intv};
        ghc_pkg::OFS_BAL: RDATA <= {16'h0, bal_thresh};
        ghc_pkg::OFS_TRIP: RDATA <= {trip_clr, trip_set};
        ghc_pkg::OFS_TEMP: RDATA <= {19'h0, TEMP_IS_FET, 3'h0, TEMP_EN};
        ghc_pkg::OFS_LED: RDATA <= {26'h0, led_show, 1'b0, led_segs};
        ghc_pkg::OFS_COUNT: RDATA <= charge_count;
        ghc_pkg::OFS_WAKE: RDATA <= {16'h0, wake_thresh};
        ghc_pkg::OFS_AUTH: RDATA <= {31'h0, auth_done_flag};
        ghc_pkg::OFS_THERM: RDATA <= {16'h0, FET_THERM_MODEL, CELL_THERM_MODEL};
        default: RDATA <= '0;
      endcase
    end
  end

  // Power mode machine
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      mode <= ghc_pkg::GHC_NORMAL;
    end else if (WR && ADDR == ghc_pkg::OFS_CTRL) begin
      case (WDATA[ghc_pkg::CTRL_MODE_LSB +: 2])
        ghc_pkg::MODE_REQ_SLEEP: mode <= ghc_pkg::GHC_SLEEP;
        ghc_pkg::MODE_REQ_SHUTDOWN: mode <= ghc_pkg::GHC_SHUTDOWN;
        default: mode <= ghc_pkg::GHC_NORMAL;
      endcase
    end else begin
      case (mode)
        ghc_pkg::GHC_SLEEP: if (next_wake) mode <= ghc_pkg::GHC_NORMAL;
        ghc_pkg::GHC_NORMAL: ;
        ghc_pkg::GHC_SHUTDOWN: ;
        default: mode <= ghc_pkg::GHC_NORMAL;
      endcase
    end
  end

  assign next_wake = FAULT_DETECT || PERMANENT_FAULT ||
                     (SENSE_VALID && sense_mag > {1'b0, wake_thresh});

  // Millisecond, run and second time base
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
      run_ms <= '0;
      run_tick <= 1'b0;
      sec_ms <= '0;
      sec_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? '0 : ms_cnt + 32'h1;
      run_tick <= 1'b0;
      sec_tick <= 1'b0;
      if (ms_tick) begin
        run_tick <= (run_ms == 16'(ghc_pkg::RUN_INTERVAL_MS - 1));
        run_ms <= (run_ms == 16'(ghc_pkg::RUN_INTERVAL_MS - 1)) ? '0 : run_ms + 16'h1;
        sec_tick <= (sec_ms == 16'(MS_PER_S - 1));
        sec_ms <= (sec_ms == 16'(MS_PER_S - 1)) ? '0 : sec_ms + 16'h1;
      end
    end
  end

  // Measurement cycle scheduling
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      MEAS_RUN <= 1'b0;
      CELL_VOLT_REFRESH <= 1'b0;
      sleep_cnt <= '0;
    end else begin
      MEAS_RUN <= 1'b0;
      CELL_VOLT_REFRESH <= 1'b0;
      if (run_tick) begin
        CELL_VOLT_REFRESH <= 1'b1;
        if (mode == ghc_pkg::GHC_NORMAL) begin
          MEAS_RUN <= 1'b1;
          sleep_cnt <= '0;
        end else if (sleep_cnt + 8'h1 >= sleep_intv) begin
          MEAS_RUN <= 1'b1;
          sleep_cnt <= '0;
        end else begin
          sleep_cnt <= sleep_cnt + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      run_active <= 1'b0;
    end else if (MEAS_RUN) begin
      run_active <= 1'b1;
    end else if (RUN_DONE) begin
      run_active <= 1'b0;
    end
  end

  // Charge direction and coulomb integration
  assign sense_diff = 17'(SENSE_POS_INPUT) - 17'(SENSE_NEG_INPUT);
  assign sense_mag = sense_diff[16] ? 17'(-sense_diff) : sense_diff;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      CHARGING <= 1'b0;
      DISCHARGING <= 1'b0;
    end else if (SENSE_VALID) begin
      CHARGING <= !sense_diff[16] && sense_diff != '0;
      DISCHARGING <= sense_diff[16];
    end
  end

  // Each count is one 0.26 nVh step of the sense integral
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      charge_count <= '0;
    end else if (alive && SENSE_VALID) begin
      charge_count <= charge_count + 32'(sense_diff);
    end
  end

  // Voltage-based balancing of each cell
  always_comb begin
    min_cell = CELL_VOLT[15:0];
    for (int i = 1; i < ghc_pkg::NCELL; i++) begin
      if (CELL_VOLT[i*16 +: 16] < min_cell) min_cell = CELL_VOLT[i*16 +: 16];
    end
  end

  for (genvar g = 0; g < ghc_pkg::NCELL; g++) begin : g_bal
    always_ff @(posedge CORE_CLK) begin
      if (!RST_N || !alive || !bal_en || !CHARGING) begin
        BALANCE[g] <= 1'b0;
      end else if (CELL_VOLT_REFRESH) begin
        BALANCE[g] <= CELL_VOLT[g*16 +: 16] >= bal_thresh &&
                      CELL_VOLT[g*16 +: 16] > min_cell;
      end
    end
  end

  // Capacity trip point
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive || !trip_en) begin
      TRIP_POINT_IRQ <= 1'b0;
    end else if (MEAS_RUN) begin
      if (REMAINING_CHARGE_VALUE <= trip_set) begin
        TRIP_POINT_IRQ <= 1'b1;
      end else if (REMAINING_CHARGE_VALUE > trip_clr) begin
        TRIP_POINT_IRQ <= 1'b0;
      end
    end
  end

  // Lifetime log timers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      stats_s <= '0;
      time_s <= '0;
      LIFE_STATS_COPY <= 1'b0;
      LIFE_TIME_COPY <= 1'b0;
    end else begin
      LIFE_STATS_COPY <= 1'b0;
      LIFE_TIME_COPY <= 1'b0;
      if (sec_tick) begin
        if (stats_s == 32'(LIFE_STATS_S - 1)) begin
          stats_s <= '0;
          LIFE_STATS_COPY <= LIFE_STATS_DIFF;
        end else begin
          stats_s <= stats_s + 32'h1;
        end
        if (time_s == 32'(LIFE_TIME_S - 1)) begin
          time_s <= '0;
          LIFE_TIME_COPY <= LIFE_TIME_DIFF;
        end else begin
          time_s <= time_s + 32'h1;
        end
      end
    end
  end

  // Segment display
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      show_phase <= 1'b0;
    end else if (sec_tick) begin
      show_phase <= !show_phase;
    end
  end

  for (genvar s = 0; s < ghc_pkg::NSEG; s++) begin : g_led
    logic cap_on;
    assign cap_on = (s < 32'(led_segs)) &&
                    10'(RELATIVE_CHARGE_PERCENT * led_segs) > 10'(s * ghc_pkg::PERCENT_FULL);
    always_ff @(posedge CORE_CLK) begin
      if (!RST_N || !alive) begin
        LED_SEG[s] <= 1'b0;
      end else if (led_show == ghc_pkg::LED_SHOW_FAULT ||
                   (led_show == ghc_pkg::LED_SHOW_BOTH && PERMANENT_FAULT && show_phase)) begin
        LED_SEG[s] <= PERMANENT_FAULT && PERMANENT_FAULT_CODE[s];
      end else begin
        LED_SEG[s] <= cap_on;
      end
    end
  end

  // Authentication handshake toward the hash engine
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !alive) begin
      AUTH_START <= 1'b0;
      auth_done_flag <= 1'b0;
    end else begin
      AUTH_START <= WR && ADDR == ghc_pkg::OFS_AUTH;
      if (AUTH_DONE) begin
        auth_done_flag <= 1'b1;
      end else if (WR && ADDR == ghc_pkg::OFS_AUTH) begin
        auth_done_flag <= 1'b0;
      end
    end
  end
endmodule

//--- bench/ghc_checker.sv
// Port-level assertions for the housekeeping block
`timescale 1ns/1ps
module ghc_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic BUS_CLOCK_PIN_OE,
  input wire logic BUS_CLOCK_PULL_LOW,
  input wire logic BUS_CLOCK_SEEN,
  input wire logic BUS_DATA_SEEN,
  input wire logic BUS_ACTIVE,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic signed [15:0] SENSE_POS_INPUT,
  input wire logic signed [15:0] SENSE_NEG_INPUT,
  input wire logic SENSE_VALID,
  input wire logic CHARGING,
  input wire logic DISCHARGING,
  input wire logic CELL_VOLT_REFRESH,
  input wire logic MEAS_RUN,
  input wire logic RUN_DONE,
  input wire logic REDUCED_POWER,
  input wire logic TRIP_POINT_IRQ_PULLUP_EN,
  input wire logic LIFE_STATS_DIFF,
  input wire logic LIFE_STATS_COPY
);
  localparam int RUN_CYC = 250 * MS_CYCLES;
  localparam int OFF_MIN = 2000 * MS_CYCLES;
  int low_c;
  int gap_c;
  logic seen_r;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Cycles with both bus lines low
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || BUS_CLOCK_SEEN || BUS_DATA_SEEN) low_c <= 0;
    else low_c <= low_c + 1;
  end
  // Cycles since the last cell refresh
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || SHUTDOWN_ACTIVE) begin
      gap_c <= 0;
      seen_r <= 1'b0;
    end else if (CELL_VOLT_REFRESH) begin
      gap_c <= 1;
      seen_r <= 1'b1;
    end else gap_c <= gap_c + 1;
  end
  oe_gate_a: assert property (BUS_CLOCK_PIN_OE == (BUS_CLOCK_PULL_LOW && BUS_ACTIVE))
    else $error("clock pin enable not gated by bus state");
  bus_resume_a: assert property (!BUS_ACTIVE && !SHUTDOWN_ACTIVE && BUS_CLOCK_SEEN
    |-> ##[0:2] BUS_ACTIVE)
    else $error("bus did not resume after line went high");
  off_early_a: assert property ($fell(BUS_ACTIVE) && !SHUTDOWN_ACTIVE
    |-> low_c >= OFF_MIN)
    else $error("bus off entered too early");
  off_late_a: assert property (low_c == OFF_MIN + 2 * MS_CYCLES + 4 |-> !BUS_ACTIVE)
    else $error("bus off not entered");
  refresh_gap_a: assert property (CELL_VOLT_REFRESH && seen_r |-> gap_c == RUN_CYC)
    else $error("cell refresh spacing wrong");
  charge_sign_a: assert property (SENSE_VALID && !SHUTDOWN_ACTIVE
    && SENSE_POS_INPUT > SENSE_NEG_INPUT |=> CHARGING && !DISCHARGING)
    else $error("positive sense not charging");
  discharge_sign_a: assert property (SENSE_VALID && !SHUTDOWN_ACTIVE
    && SENSE_POS_INPUT < SENSE_NEG_INPUT |=> DISCHARGING && !CHARGING)
    else $error("negative sense not discharging");
  meas_power_a: assert property (MEAS_RUN |=> !REDUCED_POWER)
    else $error("run did not leave reduced power");
  done_power_a: assert property (RUN_DONE && !MEAS_RUN && !REDUCED_POWER
    |=> REDUCED_POWER)
    else $error("reduced power not restored after run");
  shut_quiet_a: assert property (SHUTDOWN_ACTIVE && $past(SHUTDOWN_ACTIVE)
    |-> !MEAS_RUN && !CELL_VOLT_REFRESH && !BUS_ACTIVE && !TRIP_POINT_IRQ_PULLUP_EN)
    else $error("activity during shutdown");
  stats_copy_a: assert property (LIFE_STATS_COPY
    |-> $past(LIFE_STATS_DIFF) ##1 !LIFE_STATS_COPY)
    else $error("statistics copy without difference");
  bus_off_c: cover property ($fell(BUS_ACTIVE) && !SHUTDOWN_ACTIVE);
  copy_c: cover property (LIFE_STATS_COPY);
  run_c: cover property (MEAS_RUN ##1 !REDUCED_POWER);
endmodule
bind ghc_top ghc_checker #(.MS_CYCLES(MS_CYCLES)) i_ghc_checker (.*);

//--- bench/ghc_host.sv
// Host-side bus model: open-drain lines with pull-ups and a framed bus clock
`timescale 1ns/1ps
module ghc_host (
  input wire logic clk,
  input wire logic hold_low,
  input wire logic frame,
  input wire logic clk_oe,
  input wire logic data_oe,
  output logic scl,
  output logic sda
);
  logic [2:0] div;
  logic scl_h;
  logic sda_h;
  // Clock toggles every 80 ns inside a frame and stands high outside
  always_ff @(posedge clk) begin
    if (!frame) begin
      div <= 3'h0;
      scl_h <= 1'b1;
      sda_h <= 1'b1;
    end else begin
      div <= div + 3'h1;
      if (div == 3'h7) scl_h <= !scl_h;
      if (div == 3'h3 && !scl_h) sda_h <= !sda_h;
    end
  end
  // Pull-ups win unless a party drives low; releasing leaves bus-off
  assign scl = !(hold_low || !scl_h || clk_oe);
  assign sda = !(hold_low || !sda_h || data_oe);
endmodule

//--- bench/ghc_top_bench.sv
// Self-checking bench for the housekeeping block
`timescale 1ns/1ps
module ghc_top_bench;
  localparam int RUN = 2500;
  logic CORE_CLK = 0, RST_N = 0, WR = 0, RD = 0, hold_low = 0, frame = 0, rd_d = 0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic BUS_CLOCK_PIN_IN, BUS_CLOCK_PIN_OUT, BUS_CLOCK_PIN_OE, BUS_DATA_PIN_IN;
  logic BUS_DATA_PIN_OUT, BUS_DATA_PIN_OE, BUS_CLOCK_SEEN, BUS_DATA_SEEN, BUS_ACTIVE;
  logic BUS_MASTER_EN, BUS_PEC_EN, CHARGING, DISCHARGING, CELL_VOLT_REFRESH, TRIP_POINT_IRQ;
  logic BUS_CLOCK_PULL_LOW = 0, BUS_DATA_PULL_LOW = 0, SENSE_VALID = 0, RUN_DONE = 0;
  logic LIFE_STATS_DIFF = 0, LIFE_TIME_DIFF = 0, FAULT_DETECT = 0, PERMANENT_FAULT = 0;
  logic TRIP_POINT_IRQ_PULLUP_EN, LIFE_STATS_COPY, LIFE_TIME_COPY, MEAS_RUN, REDUCED_POWER;
  logic SHUTDOWN_ACTIVE, AUTH_START, AUTH_DONE = 0;
  logic signed [15:0] SENSE_POS_INPUT = 16'h0, SENSE_NEG_INPUT = 16'h0;
  logic [63:0] CELL_VOLT = 64'h0;
  logic [3:0] BALANCE;
  logic [15:0] REMAINING_CHARGE_VALUE = 16'h0;
  logic [4:0] PERMANENT_FAULT_CODE = 5'h0, LED_SEG, TEMP_EN, TEMP_IS_FET;
  logic [6:0] RELATIVE_CHARGE_PERCENT = 7'h0;
  logic [7:0] CELL_THERM_MODEL, FET_THERM_MODEL;
  logic [31:0] exp_q[$];
  int mismatches = 0, n_compared = 0, seed = 32'h1E39, cyc = 0, last_m = 0, gap_m = 0;
  int n_meas = 0, n_ls = 0, n_lt = 0, n_auth = 0, sum = 0, a0, a1, p, n;
  ghc_top #(.MS_CYCLES(10), .MS_PER_S(4), .LIFE_STATS_S(5), .LIFE_TIME_S(3)) i_ghc_top (.*);
  ghc_host i_ghc_host (.clk(CORE_CLK), .hold_low(hold_low), .frame(frame),
    .clk_oe(BUS_CLOCK_PIN_OE), .data_oe(BUS_DATA_PIN_OE), .scl(BUS_CLOCK_PIN_IN),
    .sda(BUS_DATA_PIN_IN));
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge CORE_CLK);
    RD <= 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge CORE_CLK);
  endtask
  task automatic runs(input int k);
    int t;
    t = 0;
    a0 = n_meas + k;
    while (n_meas < a0) begin
      @(negedge CORE_CLK);
      t++;
      if (t > 9000 * k) begin
        mismatches++;
        report_and_stop;
      end
    end
  endtask
  function automatic logic [4:0] led(input int s, input int c);
    led = 5'h0;
    for (int i = 0; i < 5; i++) led[i] = (i < s) && (c * s > i * 100);
  endfunction
  // Read data checks, run spacing and pulse counts
  always @(posedge CORE_CLK) begin
    rd_d <= RD;
    RUN_DONE <= MEAS_RUN;
    if (rd_d) chk("rdata", RDATA, exp_q.pop_front());
    if (MEAS_RUN === 1'b1) begin
      gap_m = cyc - last_m;
      last_m = cyc;
      n_meas++;
    end
    n_ls += (LIFE_STATS_COPY === 1'b1);
    n_lt += (LIFE_TIME_COPY === 1'b1);
    n_auth += (AUTH_START === 1'b1);
    cyc++;
  end
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rd(8'h08, 32'h14);
    rd(8'h0C, 32'h0FA0);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h10);
    rd(8'h3C, 32'h0);
    wr(8'h00, 32'h3C);
    wr(8'h14, 32'h1A15);
    wr(8'h28, 32'hA55A);
    rd(8'h00, 32'h3C);
    ticks(1);
    chk("enables", {BUS_MASTER_EN, BUS_PEC_EN, TRIP_POINT_IRQ_PULLUP_EN}, 32'h7);
    chk("temp", {TEMP_IS_FET, TEMP_EN}, 32'h355);
    chk("therm", {FET_THERM_MODEL, CELL_THERM_MODEL}, 32'hA55A);
    $display("test registers finished");
    for (int i = 0; i < 17; i++) begin
      p = $random(seed) % 1000;
      n = (i == 0) ? p : $random(seed) % 1000;
      if (i == 16) p = n + 500;
      @(posedge CORE_CLK);
      SENSE_POS_INPUT <= 16'(p);
      SENSE_NEG_INPUT <= 16'(n);
      SENSE_VALID <= 1'b1;
      sum += p - n;
      @(posedge CORE_CLK);
      SENSE_VALID <= 1'b0;
      ticks(1);
      chk("sign", {CHARGING, DISCHARGING}, {30'h0, p > n, p < n});
    end
    rd(8'h1C, 32'(sum));
    $display("test sense finished");
    @(posedge CORE_CLK);
    CELL_VOLT <= {16'h0FA0, 16'h1100, 16'h0F00, 16'h1000};
    REMAINING_CHARGE_VALUE <= 16'h0080;
    wr(8'h10, 32'h0200_0100);
    runs(2);
    ticks(3);
    chk("run gap", gap_m, RUN);
    chk("trip set", TRIP_POINT_IRQ, 32'h1);
    chk("balance", BALANCE, 32'hD);
    @(posedge CORE_CLK);
    REMAINING_CHARGE_VALUE <= 16'h0300;
    runs(1);
    ticks(3);
    chk("trip clear", TRIP_POINT_IRQ, 32'h0);
    rd(8'h04, 32'h04);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h3D);
    runs(2);
    chk("sleep gap", gap_m, 3 * RUN);
    @(posedge CORE_CLK);
    FAULT_DETECT <= 1'b1;
    @(posedge CORE_CLK);
    FAULT_DETECT <= 1'b0;
    rd(8'h00, 32'h3C);
    wr(8'h00, 32'h3D);
    @(posedge CORE_CLK);
    SENSE_VALID <= 1'b1;
    @(posedge CORE_CLK);
    SENSE_VALID <= 1'b0;
    rd(8'h00, 32'h3C);
    $display("test scheduler finished");
    for (int v = 1; v >= 0; v--) begin
      @(posedge CORE_CLK);
      LIFE_STATS_DIFF <= v[0];
      LIFE_TIME_DIFF <= v[0];
      ticks(2);
      a0 = n_ls;
      a1 = n_lt;
      ticks(1200);
      chk("stats copies", n_ls - a0, 6 * v);
      chk("time copies", n_lt - a1, 10 * v);
    end
    $display("test lifetime finished");
    for (int s = 3; s <= 6; s++) begin
      p = {$random(seed)} % 101;
      @(posedge CORE_CLK);
      RELATIVE_CHARGE_PERCENT <= 7'(p);
      PERMANENT_FAULT <= (s == 6);
      PERMANENT_FAULT_CODE <= 5'(p);
      wr(8'h18, (s == 6) ? 32'h15 : 32'(s));
      ticks(100);
      chk("led", LED_SEG, (s == 6) ? 5'(p) : led(s, p));
    end
    @(posedge CORE_CLK);
    PERMANENT_FAULT <= 1'b0;
    frame <= 1'b1;
    $display("test display finished");
    repeat (200) begin
      @(posedge CORE_CLK);
      BUS_CLOCK_PULL_LOW <= 1'($random(seed));
      BUS_DATA_PULL_LOW <= 1'($random(seed));
    end
    @(posedge CORE_CLK);
    frame <= 1'b0;
    BUS_CLOCK_PULL_LOW <= 1'b0;
    BUS_DATA_PULL_LOW <= 1'b0;
    hold_low <= 1'b1;
    ticks(12000);
    @(posedge CORE_CLK);
    hold_low <= 1'b0;
    ticks(50);
    @(posedge CORE_CLK);
    hold_low <= 1'b1;
    BUS_CLOCK_PULL_LOW <= 1'b1;
    ticks(12000);
    chk("still active", BUS_ACTIVE, 32'h1);
    ticks(8100);
    chk("bus off", BUS_ACTIVE, 32'h0);
    chk("lines", {BUS_CLOCK_SEEN, BUS_DATA_SEEN, BUS_CLOCK_PIN_OUT, BUS_DATA_PIN_OUT}, 32'h0);
    rd(8'h04, 32'h24);
    @(posedge CORE_CLK);
    hold_low <= 1'b0;
    BUS_CLOCK_PULL_LOW <= 1'b0;
    ticks(100);
    chk("resume", {BUS_ACTIVE, BUS_CLOCK_SEEN, BUS_DATA_SEEN}, 32'h7);
    $display("test bus off finished");
    wr(8'h00, 32'h06);
    ticks(2);
    a0 = n_meas;
    ticks(3000);
    chk("shutdown", {SHUTDOWN_ACTIVE, TRIP_POINT_IRQ_PULLUP_EN, BUS_ACTIVE}, 32'h4);
    chk("shutdown runs", n_meas - a0, 32'h0);
    wr(8'h00, 32'h0);
    ticks(2);
    chk("shutdown exit", SHUTDOWN_ACTIVE, 32'h0);
    a0 = n_auth;
    wr(8'h24, 32'h1);
    @(posedge CORE_CLK);
    AUTH_DONE <= 1'b1;
    @(posedge CORE_CLK);
    AUTH_DONE <= 1'b0;
    ticks(2);
    chk("auth start", n_auth - a0, 32'h1);
    rd(8'h24, 32'h1);
    ticks(4);
    $display("test shutdown and auth finished");
    report_and_stop;
  end
endmodule
